// ===== hdl/cmd_decode_pkg.sv
// shared constants and types for the command/address decoder pair
`default_nettype none
package cmd_decode_pkg;
  localparam int ADDR_W      = 18;
  localparam int BANK_W      = 2;
  localparam int GROUP_W     = 2;
  localparam int STACK_W     = 3;
  localparam int BANKS_TOTAL = 16;
  // bit positions within the address bus
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int CHOP_BIT       = 12;
  localparam int WE_ROW_BIT     = 14;
  localparam int CAS_ROW_BIT    = 15;
  localparam int RAS_ROW_BIT    = 16;
  // keep-alive interval: 8192 refresh intervals of 7800 ns each
  localparam int KEEPALIVE_INTERVALS = 8192;
  localparam int REFRESH_INTERVAL_NS = 7800;
  localparam int CLK_PERIOD_NS       = 40;
  localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int KEEPALIVE_CYC = KEEPALIVE_INTERVALS * REFRESH_INTERVAL_CYC;
  // {row, column, write} strobe-low encodings with row-open high
  localparam logic [2:0] ENC_MRS  = 3'h0;
  localparam logic [2:0] ENC_REF  = 3'h1;
  localparam logic [2:0] ENC_PRE  = 3'h2;
  localparam logic [2:0] ENC_WR   = 3'h4;
  localparam logic [2:0] ENC_RD   = 3'h5;
  localparam logic [2:0] ENC_NOP  = 3'h7;
  typedef enum logic [2:0] {
    OP_NONE, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_REF, OP_MRS, OP_NOP
  } op_t;
endpackage : cmd_decode_pkg
`default_nettype wire

// ===== hdl/cmd_addr_if.sv
// command/address link between controller and device
`default_nettype none
interface cmd_addr_if;
  import cmd_decode_pkg::*;
  logic               clk_true;
  logic               clk_complement;
  logic               chip_select_low;
  logic               clock_gate;
  logic               termination_input;
  logic               row_open_strobe_low;
  logic [ADDR_W-1:0]  addr;
  logic [BANK_W-1:0]  bank_select;
  logic [GROUP_W-1:0] group_select;
  logic [STACK_W-1:0] stack_id_inputs;
  modport ctrl (output clk_true, clk_complement, chip_select_low, clock_gate,
                termination_input, row_open_strobe_low, addr, bank_select,
                group_select, stack_id_inputs);
  modport dev  (input clk_true, clk_complement, chip_select_low, clock_gate,
                termination_input, row_open_strobe_low, addr, bank_select,
                group_select, stack_id_inputs);
endinterface : cmd_addr_if
`default_nettype wire

// ===== hdl/sdram_cmd_addr_decode.sv
// device end: samples the command/address pins and decodes operations
// Summary of operation
// - sample inputs on true-rise/complement-fall crossing
// - controller uses deselect, not no-operation; its chip-select keep-alive slots send the no-operation encoding
// - controller toggles clock gate every 8192 intervals
// - chip select toggle alternative; self refresh exempt
// - controller uses only defined functions
// - single byte lane uses lower byte
// - address is row on activate, column on access
// - address is opcode on mode register set
// - auto-close flag selects auto precharge
// - precharge closes all banks when flag high
// - chop select high full, low chopped
// - row-open low: strobes are upper row bits
// - row-open high: strobes are command encodings
// - bank select picks bank or mode register
// - group select picks group and mode register
// - eight-bit part has four groups of four
// - stack id selects die in tall stacks
// - chip select high masks every command
`default_nettype none
module sdram_cmd_addr_decode
  import cmd_decode_pkg::*;
#(
  parameter bit           WIDE_X16 = 1'b0,
  parameter int           STACK_H  = 1,
  parameter logic [2:0]   DIE_ID   = 3'h0
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  // link
  cmd_addr_if.dev                  link,
  // decoded operation
  output logic                     o_valid,
  output op_t                      o_op,
  output logic [ADDR_W-1:0]        o_row,
  output logic [ADDR_W-1:0]        o_col,
  output logic [ADDR_W-1:0]        o_opcode,
  output logic [GROUP_W-1:0]       o_group,
  output logic [BANK_W-1:0]        o_bank,
  output logic [GROUP_W+BANK_W-1:0] o_mode_reg,
  output logic                     o_auto_close,
  output logic                     o_full_burst,
  output logic                     o_all_banks,
  output logic [BANKS_TOTAL-1:0]   o_open_banks
);
  // two-stage synchronisers for the link clock pair and every pin
  // the link clock must run at half of i_clk or slower, or crossings are missed
  // pins and clock pair share one depth, so a command lines up with its edge
  localparam int PIN_W = 4 + ADDR_W + BANK_W + GROUP_W + STACK_W;
  logic [PIN_W-1:0] meta_ff;
  logic [PIN_W-1:0] pins_ff;
  logic [1:0]       clk_meta_ff;
  logic [1:0]       clk_sync_ff;
  logic [1:0]       clk_prev_ff;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_ff     <= '1;
      pins_ff     <= '1;
      clk_meta_ff <= 2'h2;
      clk_sync_ff <= 2'h2;
      clk_prev_ff <= 2'h2;
    end else begin
      meta_ff     <= {link.chip_select_low, link.clock_gate, link.termination_input,
                      link.row_open_strobe_low, link.addr, link.bank_select,
                      link.group_select, link.stack_id_inputs};
      pins_ff     <= meta_ff;
      clk_meta_ff <= {link.clk_complement, link.clk_true};
      clk_sync_ff <= clk_meta_ff;
      clk_prev_ff <= clk_sync_ff;
    end
  end

  // unpack the synchronised pins
  // the termination input rides along but plays no part in decoding
  logic               cs_low;
  logic               ck_gate;
  logic               row_open_low;
  logic [ADDR_W-1:0]  a;
  logic [BANK_W-1:0]  ba;
  logic [GROUP_W-1:0] bg;
  logic [STACK_W-1:0] sid;
  logic               term_unused;
  assign {cs_low, ck_gate, term_unused, row_open_low, a, ba, bg, sid} = pins_ff;

  // crossing edge detect: true rises while complement falls
  // both wires of the pair must agree, so a glitch on one alone is ignored
  logic crossing;
  assign crossing = clk_sync_ff[0] && !clk_prev_ff[0] && !clk_sync_ff[1] && clk_prev_ff[1];

  // die select from stack id in tall stacks only
  // a flat part or a short stack answers every selected slot
  logic die_hit;
  always_comb begin
    die_hit = 1'b1;
    if (!WIDE_X16 && (STACK_H == 4 || STACK_H == 8)) begin
      die_hit = (sid == DIE_ID);
    end
  end

  // upper group bit ignored on sixteen-bit part
  // forcing it low keeps a stray level from naming a missing group
  logic [GROUP_W-1:0] grp;
  assign grp = WIDE_X16 ? {1'b0, bg[0]} : bg;

  // decode of strobe levels into operations
  op_t cmd;
  always_comb begin
    cmd = OP_NONE;
    // row-open low means activate, strobes are row bits
    if (!row_open_low) begin
      cmd = OP_ACT;
    end else begin
      unique case (a[RAS_ROW_BIT:WE_ROW_BIT])
        ENC_MRS: cmd = OP_MRS;
        ENC_REF: cmd = OP_REF;
        ENC_PRE: cmd = OP_PRE;
        ENC_WR:  cmd = OP_WR;
        ENC_RD:  cmd = OP_RD;
        ENC_NOP: cmd = OP_NOP;
        // encodings 3 and 6 are undefined and decode to nothing
        default: cmd = OP_NONE;
      endcase
    end
  end

  // chip select high masks the command
  // a low gate or another die's id blocks the command as well
  logic take;
  assign take = crossing && !cs_low && ck_gate && die_hit && (cmd != OP_NONE);

  // decoded operation registers
  // data fields hold until the next command that owns them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_valid      <= 1'b0;
      o_op         <= OP_NONE;
      o_row        <= '0;
      o_col        <= '0;
      o_opcode     <= '0;
      o_group      <= '0;
      o_bank       <= '0;
      o_mode_reg   <= '0;
      o_auto_close <= 1'b0;
      o_full_burst <= 1'b1;
      o_all_banks  <= 1'b0;
    end else begin
      // only a selected, clocked command pulses valid
      o_valid <= take;
      if (take) begin
        o_op <= cmd;
        o_group <= grp;
        o_bank  <= ba;
        if (cmd == OP_ACT) begin
          o_row <= a;
        end
        // column address on read and write
        if (cmd == OP_RD || cmd == OP_WR) begin
          o_col <= a;
          o_auto_close <= a[AUTO_CLOSE_BIT];
          o_full_burst <= a[CHOP_BIT];
        end
        if (cmd == OP_MRS) begin
          o_opcode   <= a;
          o_mode_reg <= {grp, ba};
        end
        o_all_banks <= (cmd == OP_PRE) && a[AUTO_CLOSE_BIT];
      end
    end
  end

  // open-bank tracking: four groups of four banks
  logic [3:0] idx;
  assign idx = {grp, ba};

  // one bit per bank; precharge of all banks overrides the index
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_open_banks <= '0;
    end else if (take) begin
      // bank index from group and bank
      if (cmd == OP_ACT) begin
        o_open_banks[idx] <= 1'b1;
      end else if (cmd == OP_PRE) begin
        if (a[AUTO_CLOSE_BIT]) begin
          o_open_banks <= '0;
        end else begin
          o_open_banks[idx] <= 1'b0;
        end
      end else if ((cmd == OP_RD || cmd == OP_WR) && a[AUTO_CLOSE_BIT]) begin
        o_open_banks[idx] <= 1'b0;
      end
    end
  end
endmodule // sdram_cmd_addr_decode
`default_nettype wire

// ===== hdl/sdram_cmd_ctrl.sv
// controller end: drives the command/address pins from user requests
`default_nettype none
module sdram_cmd_ctrl
  import cmd_decode_pkg::*;
#(
  parameter int KEEPALIVE = KEEPALIVE_CYC
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  // user request
  input  wire logic                i_req,
  input  wire op_t                 i_op,
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic [GROUP_W-1:0]  i_group,
  input  wire logic [BANK_W-1:0]   i_bank,
  input  wire logic [STACK_W-1:0]  i_stack_id,
  input  wire logic                i_gate_fixed_high,
  input  wire logic                i_self_refresh,
  input  wire logic                i_allow_nop,
  output logic                     o_busy,
  // link
  cmd_addr_if.ctrl                 link
);
  // link clock divider: one command slot per two cycles
  logic ck_ff;
  logic busy_ff;
  logic cs_low_ff;
  logic gate_ff;
  logic act_low_ff;
  logic [ADDR_W-1:0]  a_ff;
  logic [BANK_W-1:0]  ba_ff;
  logic [GROUP_W-1:0] bg_ff;
  logic [STACK_W-1:0] sid_ff;
  logic [31:0]        alive_ff;
  logic               ck_bar_ff;
  logic               kick;
  // a due toggle waits for the next command slot, so an odd interval is never lost
  assign kick = (alive_ff >= 32'(KEEPALIVE - 1)) && ck_ff && !i_self_refresh;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ck_ff     <= 1'b0;
      ck_bar_ff <= 1'b1;
    end else begin
      ck_ff     <= !ck_ff;
      ck_bar_ff <= ck_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_self_refresh || kick) begin
      alive_ff <= '0;
    end else if (alive_ff < 32'(KEEPALIVE - 1)) begin
      alive_ff <= alive_ff + 32'h1;
    end
  end

  // command pins change while the link clock is low
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cs_low_ff  <= 1'b1;
      gate_ff    <= 1'b1;
      act_low_ff <= 1'b1;
      a_ff       <= '1;
      ba_ff      <= '0;
      bg_ff      <= '0;
      sid_ff     <= '0;
      busy_ff    <= 1'b0;
    end else if (ck_ff) begin
      busy_ff    <= 1'b0;
      cs_low_ff  <= 1'b1;
      // toggle gate; toggle chip select when gate fixed
      if (kick && !i_gate_fixed_high) begin
        gate_ff <= !gate_ff;
      end else if (!kick) begin
        gate_ff <= 1'b1;
      end
      // only defined ops; no-operation only when allowed
      // a command never rides a slot in which the clock gate drops
      if (i_req && i_op != OP_NONE && (i_op != OP_NOP || i_allow_nop)
          && !(kick && !i_gate_fixed_high)) begin
        busy_ff   <= 1'b1;
        cs_low_ff <= 1'b0;
        ba_ff     <= i_bank;
        bg_ff     <= i_group;
        sid_ff    <= i_stack_id;
        act_low_ff <= (i_op != OP_ACT);
        unique case (i_op)
          OP_ACT:  a_ff <= i_addr;
          OP_RD:   a_ff <= {1'b1, ENC_RD, i_addr[WE_ROW_BIT-1:0]};
          OP_WR:   a_ff <= {1'b1, ENC_WR, i_addr[WE_ROW_BIT-1:0]};
          OP_PRE:  a_ff <= {1'b1, ENC_PRE, i_addr[WE_ROW_BIT-1:0]};
          OP_REF:  a_ff <= {1'b1, ENC_REF, i_addr[WE_ROW_BIT-1:0]};
          OP_MRS:  a_ff <= {1'b1, ENC_MRS, i_addr[WE_ROW_BIT-1:0]};
          OP_NOP:  a_ff <= {1'b1, ENC_NOP, i_addr[WE_ROW_BIT-1:0]};
          default: a_ff <= '1;
        endcase
        if (i_op == OP_ACT) begin
          act_low_ff <= 1'b0;
        end
      end else if (kick && i_gate_fixed_high) begin
        // no-operation pulse on chip select with row-open high and all ones
        cs_low_ff  <= 1'b0;
        act_low_ff <= 1'b1;
        a_ff       <= '1;
      end
    end
  end

  assign o_busy                   = busy_ff;
  assign link.clk_true            = ck_ff;
  assign link.clk_complement      = ck_bar_ff;
  assign link.chip_select_low     = cs_low_ff;
  assign link.clock_gate          = gate_ff;
  // no upper byte lane on this link; data stays on the lower lane
  assign link.termination_input   = 1'b0;
  assign link.row_open_strobe_low = act_low_ff;
  assign link.addr                = a_ff;
  assign link.bank_select         = ba_ff;
  assign link.group_select        = bg_ff;
  assign link.stack_id_inputs     = sid_ff;
endmodule // sdram_cmd_ctrl
`default_nettype wire

// ===== sim/link_chk.sv
// assertions on the command/address link between the two ends
`default_nettype none
module link_chk
  import cmd_decode_pkg::*;
#(
  parameter int KEEP = 16
) (
  // clock and reset
  input wire logic               i_clk,
  input wire logic               i_sys_rst,
  // link signals
  input wire logic               clk_true,
  input wire logic               clk_complement,
  input wire logic               chip_select_low,
  input wire logic               clock_gate,
  input wire logic               row_open_strobe_low,
  input wire logic [ADDR_W-1:0]  addr,
  input wire logic [BANK_W-1:0]  bank_select,
  input wire logic [GROUP_W-1:0] group_select,
  // controller mode
  input wire logic               self_refresh
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] idle_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // cycles since the last chip-select slot or gate drop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !chip_select_low || !clock_gate || self_refresh) begin
      idle_ff <= 32'h0;
    end else begin
      idle_ff <= idle_ff + 32'h1;
    end
  end
  a_pair_inverse: assert property (clk_complement != clk_true)
    else $error("link clock pair not complementary");
  // link clock high for one cycle only
  a_clk_half: assert property (clk_true |=> !clk_true)
    else $error("link clock held high too long");
  // chip select and row-open strobe steady at the sampling crossing
  a_rise_stable: assert property ($rose(clk_true) |->
    $stable(chip_select_low) && $stable(row_open_strobe_low)) else $error("pins moved at rise");
  // address and selects move only with the falling link clock
  a_addr_on_fall: assert property ($changed({addr, bank_select, group_select}) |->
    $fell(clk_true)) else $error("address changed off the falling link clock");
  // a selected slot lasts a whole link period
  a_cs_slot: assert property ($fell(chip_select_low) |=> !chip_select_low)
    else $error("chip select slot too short");
  a_defined_enc: assert property (!chip_select_low && row_open_strobe_low |->
    !(addr[RAS_ROW_BIT:WE_ROW_BIT] inside {3'h3, 3'h6})) else $error("undefined encoding");
  // commands only while the clock gate is high
  a_gate_on_cmd: assert property (!chip_select_low |-> clock_gate)
    else $error("command sent with clock gate low");
  a_keepalive: assert property (idle_ff <= KEEP + 4)
    else $error("keep-alive toggle missing");
endmodule // link_chk
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench: controller and decoder joined by the link
`default_nettype none
module testbench
  import cmd_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int KEEP = 16;
  logic              i_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic              req = 1'b0;
  op_t               op = OP_NONE;
  logic [ADDR_W-1:0] addr = '0;
  logic [1:0]        grp = 2'h0;
  logic [1:0]        bnk = 2'h0;
  logic              busy, valid, auto_close, full_burst, all_banks;
  op_t               dec_op;
  logic [ADDR_W-1:0] row, col, opcode;
  logic [1:0]        group, bank;
  logic [3:0]        mode_reg;
  logic [15:0]       open_banks;
  int                num_errors = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  logic              gate_fixed = 1'b1;
  logic              self_ref = 1'b0;
  logic              seen_busy = 1'b0;
  int                nops = 0;
  int                gate_lows = 0;
  int                takes = 0;
  int                sent = 0;
  cmd_addr_if link_if ();
  // 25 MHz clock
  always #20 i_clk = ~i_clk;
  sdram_cmd_ctrl #(.KEEPALIVE(KEEP)) sdram_cmd_ctrl_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req), .i_op(op), .i_addr(addr),
    .i_group(grp), .i_bank(bnk), .i_stack_id(3'h0), .i_gate_fixed_high(gate_fixed),
    .i_self_refresh(self_ref), .i_allow_nop(1'b0), .o_busy(busy), .link(link_if.ctrl));
  sdram_cmd_addr_decode sdram_cmd_addr_decode_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link_if.dev), .o_valid(valid),
    .o_op(dec_op), .o_row(row), .o_col(col), .o_opcode(opcode), .o_group(group),
    .o_bank(bank), .o_mode_reg(mode_reg), .o_auto_close(auto_close),
    .o_full_burst(full_burst), .o_all_banks(all_banks), .o_open_banks(open_banks));
  link_chk #(.KEEP(KEEP)) link_chk_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .clk_true(link_if.clk_true),
    .clk_complement(link_if.clk_complement), .chip_select_low(link_if.chip_select_low),
    .clock_gate(link_if.clock_gate), .row_open_strobe_low(link_if.row_open_strobe_low),
    .addr(link_if.addr), .bank_select(link_if.bank_select),
    .group_select(link_if.group_select), .self_refresh(self_ref));
  // count decoded commands, keep-alive no-ops and gate-low samples
  always @(negedge i_clk) begin
    if (valid === 1'b1 && dec_op === OP_NOP) begin
      nops++;
    end else if (valid === 1'b1) begin
      takes++;
    end
    if (link_if.clock_gate === 1'b0) begin
      gate_lows++;
    end
  end
  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // issue one request, wait for its decode, skip keep-alive no-ops
  task automatic send(input op_t o, input logic [ADDR_W-1:0] a, input logic [1:0] g,
                      input logic [1:0] b);
    int n;
    @(negedge i_clk);
    req = 1'b1;
    op = o;
    addr = a;
    grp = g;
    bnk = b;
    n = 0;
    while (busy !== 1'b1 && n < 8) begin
      @(negedge i_clk);
      n++;
    end
    req = 1'b0;
    sent++;
    n = 0;
    while (!(valid === 1'b1 && dec_op !== OP_NOP) && n < 16) begin
      @(negedge i_clk);
      n++;
    end
    check("valid", {31'h0, valid}, 32'h1);
    check("op", 32'(dec_op), 32'(o));
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end
  // test sequence
  initial begin
    repeat (20) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    // activate with strobe pins carrying row bits
    send(OP_ACT, 18'h2c0a5, 2'h2, 2'h1);
    check("row", row, 18'h2c0a5);
    check("group", group, 2'h2);
    check("bank", bank, 2'h1);
    check("open", open_banks, 16'h0200);
    $display("test activate done");
    // write keeps bank open, read closes it
    send(OP_WR, 18'h01005, 2'h2, 2'h1);
    check("col", col[13:0], 14'h1005);
    check("auto", auto_close, 1'b0);
    check("full", full_burst, 1'b1);
    check("open", open_banks, 16'h0200);
    send(OP_RD, 18'h00422, 2'h2, 2'h1);
    check("col", col[13:0], 14'h0422);
    check("auto", auto_close, 1'b1);
    check("full", full_burst, 1'b0);
    check("open", open_banks, 16'h0000);
    $display("test access done");
    // single and all-bank precharge
    send(OP_ACT, 18'h00011, 2'h1, 2'h3);
    send(OP_ACT, 18'h00022, 2'h0, 2'h0);
    check("open", open_banks, 16'h0081);
    send(OP_PRE, 18'h00000, 2'h1, 2'h3);
    check("all", all_banks, 1'b0);
    check("open", open_banks, 16'h0001);
    send(OP_PRE, 18'h00400, 2'h0, 2'h0);
    check("all", all_banks, 1'b1);
    check("open", open_banks, 16'h0000);
    $display("test precharge done");
    // mode register set and refresh
    send(OP_MRS, 18'h01234, 2'h1, 2'h2);
    check("opcode", opcode, {1'b1, ENC_MRS, 14'h1234});
    check("mode reg", mode_reg, 4'h6);
    send(OP_REF, 18'h00000, 2'h0, 2'h0);
    $display("test mode and refresh done");
    // idle with the gate fixed high: chip-select keep-alive slots
    nops = 0;
    repeat (100) @(negedge i_clk);
    check("keepalive nops", {31'h0, nops >= 5}, 32'h1);
    $display("test keep-alive done");
    // gate free: the clock gate itself toggles
    gate_fixed = 1'b0;
    gate_lows = 0;
    repeat (100) @(negedge i_clk);
    check("gate toggles", {31'h0, gate_lows >= 5}, 32'h1);
    gate_fixed = 1'b1;
    $display("test gate toggle done");
    // self refresh: no toggling duty at all
    self_ref = 1'b1;
    repeat (8) @(negedge i_clk);
    nops = 0;
    gate_lows = 0;
    repeat (100) @(negedge i_clk);
    check("self refresh", nops + gate_lows, 0);
    self_ref = 1'b0;
    $display("test self refresh done");
    // a no-operation request is refused
    req = 1'b1;
    op = OP_NOP;
    repeat (8) begin
      @(negedge i_clk);
      if (busy === 1'b1) begin
        seen_busy = 1'b1;
      end
    end
    req = 1'b0;
    check("nop refused", {31'h0, seen_busy}, 32'h0);
    check("takes", takes, sent);
    $display("test refusals done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
